// ===== loopdiag_ctrl.sv
// self-check and loopback test controller
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - loopback tests start only in normal or direct connection mode
// - loopback tests need 1200 bps or more, never FSK or half duplex
// - self-check of program checksum, RAM, parts at reset and on command
// - local pattern test loops generated pattern through analog path, checks it
// - silent terminal during pattern test; then three-digit error count and ok
// - test ends on timer expiry, stop command, or hang-up which drops line
// - local analog echo returns terminal characters to terminal unchanged
// - remote pattern test, when connected, sends pattern and checks remote echo
// - remote digital echo forwards terminal to line and line to terminal
// - local digital echo returns line data to line, nothing to terminal
// - zero duration disables the test timer
// - duration 1 to 255 seconds ends test after that many seconds
// - remote loop requests honoured when accepted, ignored when ignored
module loopdiag_ctrl #(
    parameter int SEC_CYCLES_P = loopdiag_pkg::SEC_CYCLES
) (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // command port
    input  wire logic                  i_cmd_valid,
    input  wire loopdiag_pkg::cmd_e    i_cmd,
    input  wire logic [7:0]            i_test_duration_setting,
    // connection state
    input  wire loopdiag_pkg::link_s   i_link,
    input  wire logic                  i_rmt_loop_req,
    input  wire logic                  i_rmt_loop_end,
    // self-check engine
    input  wire logic                  i_check_done,
    input  wire logic                  i_check_pass,
    output logic [2:0]                 o_check_sel,
    output logic                       o_selfcheck_done,
    output logic                       o_selfcheck_ok,
    // character streams
    input  wire loopdiag_pkg::char_s   i_term_rx,
    input  wire loopdiag_pkg::char_s   i_line_rx,
    input  wire logic                  i_line_tx_ready,
    output loopdiag_pkg::char_s        o_term_tx,
    output loopdiag_pkg::char_s        o_line_tx,
    // status
    output logic                       o_test_active,
    output logic                       o_analog_loop,
    output logic                       o_remote_loop_ask,
    output logic                       o_refused,
    output logic                       o_hang_up,
    output loopdiag_pkg::report_s      o_report
);
    import loopdiag_pkg::*;

    typedef enum logic [2:0] {
        ST_SELF = 3'b001,
        ST_IDLE = 3'b010,
        ST_TEST = 3'b100
    } state_e;

    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES_P - 1);

    state_e      state_q,    state_d;
    test_kind_e  kind_q,     kind_d;
    logic [2:0]  check_q,    check_d;
    logic        chk_fail_q, chk_fail_d;
    logic        accept_q,   accept_d;
    logic [31:0] tick_q,     tick_d;
    logic [7:0]  secs_q,     secs_d;
    logic [7:0]  dur_q,      dur_d;
    logic [7:0]  tx_lfsr_q,  tx_lfsr_d;
    logic [7:0]  rx_lfsr_q,  rx_lfsr_d;
    logic [11:0] errs_q,     errs_d;
    char_s       term_tx_q,  term_tx_d;
    char_s       line_tx_q,  line_tx_d;
    logic        done_q,     done_d;
    logic        ok_q,       ok_d;
    logic        refused_q,  refused_d;
    logic        hang_q,     hang_d;
    report_s     report_q,   report_d;

    logic        loop_allowed;
    logic        is_pattern;
    logic        end_test;

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        lfsr_next = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
    endfunction

    // three bcd digits, stick at 999 rather than wrap
    function automatic logic [11:0] bcd_inc(input logic [11:0] v);
        logic [11:0] r;
        r = v;
        if (v != {BCD_TOP_DIGIT, BCD_TOP_DIGIT, BCD_TOP_DIGIT}) begin
            if (v[3:0] != BCD_TOP_DIGIT) begin
                r[3:0] = v[3:0] + 4'h1;
            end else if (v[7:4] != BCD_TOP_DIGIT) begin
                r[3:0] = 4'h0;
                r[7:4] = v[7:4] + 4'h1;
            end else begin
                r[7:0]  = 8'h00;
                r[11:8] = v[11:8] + 4'h1;
            end
        end
        bcd_inc = r;
    endfunction

    always_comb begin
        loop_allowed = i_link.connected
                     && (i_link.mode == CONN_NORMAL || i_link.mode == CONN_DIRECT)
                     && (i_link.bps >= MIN_LOOP_BPS) && !i_link.fsk_hdx;
        is_pattern = (kind_q == TK_LOCAL_PATTERN) || (kind_q == TK_REMOTE_PATTERN);
        end_test = 1'b0;

        state_d    = state_q;
        kind_d     = kind_q;
        check_d    = check_q;
        chk_fail_d = chk_fail_q;
        accept_d   = accept_q;
        tick_d     = tick_q;
        secs_d     = secs_q;
        dur_d      = dur_q;
        tx_lfsr_d  = tx_lfsr_q;
        rx_lfsr_d  = rx_lfsr_q;
        errs_d     = errs_q;
        term_tx_d  = '0;
        line_tx_d  = '0;
        done_d     = 1'b0;
        ok_d       = ok_q;
        refused_d  = 1'b0;
        hang_d     = 1'b0;
        report_d   = '0;

        if (i_cmd_valid && i_cmd == CMD_ACCEPT_REMOTE_LOOP) begin
            accept_d = 1'b1;
        end else if (i_cmd_valid && i_cmd == CMD_IGNORE_REMOTE_LOOP) begin
            accept_d = 1'b0;
        end
        if (i_cmd_valid && i_cmd == CMD_HANG_UP) begin
            hang_d = 1'b1;
        end

        unique case (state_q)
            ST_SELF: begin
                if (i_check_done) begin
                    chk_fail_d = chk_fail_q | !i_check_pass;
                    check_d    = {check_q[1:0], 1'b0};
                    if (check_q[CHECK_PARTS]) begin
                        state_d = ST_IDLE;
                        done_d  = 1'b1;
                        ok_d    = !(chk_fail_q | !i_check_pass);
                    end
                end
            end
            ST_IDLE: begin
                tick_d    = '0;
                secs_d    = '0;
                dur_d     = i_test_duration_setting;
                errs_d    = '0;
                tx_lfsr_d = LFSR_SEED;
                rx_lfsr_d = LFSR_SEED;
                if (i_cmd_valid) begin
                    state_d = ST_TEST;
                    unique case (i_cmd)
                        CMD_LOCAL_ANALOG_ECHO:   kind_d = TK_LOCAL_ANALOG_ECHO;
                        CMD_LOCAL_PATTERN_TEST:  kind_d = TK_LOCAL_PATTERN;
                        CMD_REMOTE_DIGITAL_ECHO: kind_d = TK_REMOTE_DIGITAL_ECHO;
                        CMD_REMOTE_PATTERN_TEST: kind_d = TK_REMOTE_PATTERN;
                        CMD_LOCAL_DIGITAL_ECHO:  kind_d = TK_LOCAL_DIGITAL_ECHO;
                        default:                 state_d = ST_IDLE;
                    endcase
                    if (i_cmd == CMD_POWER_UP_TEST) begin
                        state_d    = ST_SELF;
                        check_d    = CHECK_FIRST;
                        chk_fail_d = 1'b0;
                    end else if (state_d == ST_TEST && !loop_allowed) begin
                        state_d   = ST_IDLE;
                        refused_d = 1'b1;
                    end
                end else if (i_rmt_loop_req && accept_q && loop_allowed) begin
                    state_d = ST_TEST;
                    kind_d  = TK_SERVE_REMOTE;
                end
            end
            ST_TEST: begin
                // second ticker only runs when a duration is set
                if (dur_q != 8'h00) begin
                    tick_d = (tick_q == SEC_LAST) ? '0 : tick_q + 32'd1;
                    if (tick_q == SEC_LAST) begin
                        secs_d = secs_q + 8'h01;
                        if (secs_q + 8'h01 == dur_q) begin
                            end_test = 1'b1;
                        end
                    end
                end
                if (i_cmd_valid && (i_cmd == CMD_STOP_TEST || i_cmd == CMD_HANG_UP)) begin
                    end_test = 1'b1;
                end
                if (kind_q == TK_SERVE_REMOTE && i_rmt_loop_end) begin
                    end_test = 1'b1;
                end

                unique case (kind_q)
                    TK_LOCAL_ANALOG_ECHO: begin
                        term_tx_d = i_term_rx;
                    end
                    TK_REMOTE_DIGITAL_ECHO: begin
                        line_tx_d = i_term_rx;
                        term_tx_d = i_line_rx;
                    end
                    TK_LOCAL_DIGITAL_ECHO, TK_SERVE_REMOTE: begin
                        line_tx_d = i_line_rx;
                    end
                    TK_LOCAL_PATTERN, TK_REMOTE_PATTERN: begin
                        // terminal stays silent, pattern paced by line readiness
                        if (i_line_tx_ready && !end_test) begin
                            line_tx_d = '{valid: 1'b1, data: tx_lfsr_q};
                            tx_lfsr_d = lfsr_next(tx_lfsr_q);
                        end
                        if (i_line_rx.valid) begin
                            rx_lfsr_d = lfsr_next(rx_lfsr_q);
                            if (i_line_rx.data != rx_lfsr_q) begin
                                errs_d = bcd_inc(errs_q);
                            end
                        end
                    end
                    default: begin
                        end_test = 1'b1;
                    end
                endcase

                if (end_test) begin
                    state_d   = ST_IDLE;
                    line_tx_d = '0;
                    term_tx_d = '0;
                    if (is_pattern) begin
                        report_d = '{valid: 1'b1, hundreds: errs_d[11:8],
                                     tens: errs_d[7:4], ones: errs_d[3:0], ok: 1'b1};
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q    <= ST_SELF;
            kind_q     <= TK_LOCAL_ANALOG_ECHO;
            check_q    <= CHECK_FIRST;
            chk_fail_q <= 1'b0;
            accept_q   <= 1'b0;
            tick_q     <= '0;
            secs_q     <= '0;
            dur_q      <= '0;
            tx_lfsr_q  <= LFSR_SEED;
            rx_lfsr_q  <= LFSR_SEED;
            errs_q     <= '0;
            term_tx_q  <= '0;
            line_tx_q  <= '0;
            done_q     <= 1'b0;
            ok_q       <= 1'b0;
            refused_q  <= 1'b0;
            hang_q     <= 1'b0;
            report_q   <= '0;
        end else begin
            state_q    <= state_d;
            kind_q     <= kind_d;
            check_q    <= check_d;
            chk_fail_q <= chk_fail_d;
            accept_q   <= accept_d;
            tick_q     <= tick_d;
            secs_q     <= secs_d;
            dur_q      <= dur_d;
            tx_lfsr_q  <= tx_lfsr_d;
            rx_lfsr_q  <= rx_lfsr_d;
            errs_q     <= errs_d;
            term_tx_q  <= term_tx_d;
            line_tx_q  <= line_tx_d;
            done_q     <= done_d;
            ok_q       <= ok_d;
            refused_q  <= refused_d;
            hang_q     <= hang_d;
            report_q   <= report_d;
        end
    end

    assign o_check_sel       = (state_q == ST_SELF) ? check_q : 3'b000;
    assign o_selfcheck_done  = done_q;
    assign o_selfcheck_ok    = ok_q;
    assign o_term_tx         = term_tx_q;
    assign o_line_tx         = line_tx_q;
    assign o_test_active     = (state_q == ST_TEST);
    assign o_analog_loop     = (state_q == ST_TEST) && (kind_q == TK_LOCAL_ANALOG_ECHO
                                                     || kind_q == TK_LOCAL_PATTERN);
    assign o_remote_loop_ask = (state_q == ST_TEST) && (kind_q == TK_REMOTE_DIGITAL_ECHO
                                                     || kind_q == TK_REMOTE_PATTERN);
    assign o_refused         = refused_q;
    assign o_hang_up         = hang_q;
    assign o_report          = report_q;

    a_refuse_bad_mode: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_IDLE && i_cmd_valid && i_cmd == CMD_LOCAL_PATTERN_TEST
         && !(i_link.mode == CONN_NORMAL || i_link.mode == CONN_DIRECT))
        |=> o_refused && state_q == ST_IDLE)
        else $error("loop test started outside normal or direct mode");

    a_refuse_slow_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_IDLE && i_cmd_valid && i_cmd == CMD_LOCAL_DIGITAL_ECHO
         && (i_link.bps < MIN_LOOP_BPS || i_link.fsk_hdx)) |=> !o_test_active)
        else $error("loop test started at low speed");

    a_selfcheck_power: assert property (@(posedge i_clk)
        $fell(i_rst) |-> o_check_sel == CHECK_FIRST)
        else $error("self-check not running after reset");

    a_silent_pattern: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_test_active && $past(is_pattern) && is_pattern) |-> !o_term_tx.valid)
        else $error("terminal output during pattern test");

    a_stop_ends_test: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_TEST && i_cmd_valid && i_cmd == CMD_STOP_TEST)
        |=> !o_test_active ##0 (o_report.valid == $past(is_pattern)))
        else $error("stop command did not end test");

    a_analog_echo: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_TEST && kind_q == TK_LOCAL_ANALOG_ECHO && !end_test)
        |=> o_term_tx == $past(i_term_rx))
        else $error("local analog echo altered data");

    a_digital_echo: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_TEST && kind_q == TK_LOCAL_DIGITAL_ECHO && !end_test)
        |=> o_line_tx == $past(i_line_rx) && !o_term_tx.valid)
        else $error("local digital echo wrong");

    a_no_timer_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_TEST && dur_q == 8'h00) |-> tick_q == '0)
        else $error("timer running with zero duration");

    a_errs_saturate: assert property (@(posedge i_clk) disable iff (i_rst)
        (errs_q == 12'h999 && state_q == ST_TEST) |=> errs_q == 12'h999)
        else $error("error count passed 999");

    a_ignore_remote: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == ST_IDLE && !accept_q && !i_cmd_valid && i_rmt_loop_req) |=> !o_test_active)
        else $error("remote loop request honoured while ignored");

endmodule // loopdiag_ctrl

`default_nettype wire

// ===== loopdiag_ctrl_test.sv
// self-checking bench for the loopback diagnostics controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin miscompares++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module loopdiag_ctrl_test;
    import loopdiag_pkg::*;
    localparam int SEC = 10;
    logic        i_clk, i_rst, i_cmd_valid, i_rmt_loop_req, i_rmt_loop_end, i_line_tx_ready;
    logic        i_check_done, i_check_pass, echo_en, corrupt, pat_mode;
    logic        o_selfcheck_done, o_selfcheck_ok, o_test_active, o_analog_loop;
    logic        o_remote_loop_ask, o_refused, o_hang_up;
    logic [2:0]  o_check_sel, fail_sel;
    logic [7:0]  i_test_duration_setting, lfsr;
    cmd_e        i_cmd;
    link_s       i_link;
    char_s       i_term_rx, i_line_rx, o_term_tx, o_line_tx, tb_line;
    report_s     o_report;
    int          miscompares, num_checks, seed, cycles, bad;
    logic [15:0] exp_q[4][$];
    link_s       bad_l[5] = '{'{1'b0, CONN_NORMAL, 15'd2400, 1'b0},
        '{1'b1, CONN_RELIABLE, 15'd2400, 1'b0}, '{1'b1, CONN_AUTO, 15'd2400, 1'b0},
        '{1'b1, CONN_DIRECT, 15'd1199, 1'b0}, '{1'b1, CONN_NORMAL, 15'd9600, 1'b1}};
    cmd_e        loops[5] = '{CMD_LOCAL_ANALOG_ECHO, CMD_LOCAL_PATTERN_TEST,
        CMD_REMOTE_DIGITAL_ECHO, CMD_REMOTE_PATTERN_TEST, CMD_LOCAL_DIGITAL_ECHO};

    loopdiag_ctrl #(.SEC_CYCLES_P(SEC)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_test_duration_setting(i_test_duration_setting),
        .i_link(i_link), .i_rmt_loop_req(i_rmt_loop_req), .i_rmt_loop_end(i_rmt_loop_end),
        .i_check_done(i_check_done), .i_check_pass(i_check_pass), .o_check_sel(o_check_sel),
        .o_selfcheck_done(o_selfcheck_done), .o_selfcheck_ok(o_selfcheck_ok),
        .i_term_rx(i_term_rx), .i_line_rx(i_line_rx), .i_line_tx_ready(i_line_tx_ready),
        .o_term_tx(o_term_tx), .o_line_tx(o_line_tx), .o_test_active(o_test_active),
        .o_analog_loop(o_analog_loop), .o_remote_loop_ask(o_remote_loop_ask),
        .o_refused(o_refused), .o_hang_up(o_hang_up), .o_report(o_report));
    loopdiag_far_end far_u (.i_clk(i_clk), .i_rst(i_rst), .i_check_sel(o_check_sel),
        .i_fail_sel(fail_sel), .o_check_done(i_check_done), .o_check_pass(i_check_pass),
        .i_line_tx(o_line_tx), .i_tb_line(tb_line), .i_echo_en(echo_en),
        .i_corrupt(corrupt), .o_line_rx(i_line_rx), .o_bad_cnt(bad));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // whole run is near 4500 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic take(input int k, input logic [15:0] v);
        logic [15:0] w;
        if (exp_q[k].size() == 0) begin
            miscompares++;
            $display("unexpected at %0t: extra result %0h", $time, v);
        end else begin
            w = exp_q[k].pop_front();
            `CHK(v, w)
        end
    endtask

    // results are compared in arrival order, one queue each for terminal, line and report, one shared by the status pulses
    always @(posedge i_clk) begin
        if (!i_rst) begin
            if (o_term_tx.valid === 1'b1) take(0, {8'h00, o_term_tx.data});
            if (o_line_tx.valid === 1'b1 && !pat_mode)
                take(1, {8'h00, o_line_tx.data});
            if (o_line_tx.valid === 1'b1 && pat_mode) begin
                `CHK(o_line_tx.data, lfsr)
                lfsr = lfsr[0] ? (lfsr >> 1) ^ LFSR_TAPS : lfsr >> 1;
            end
            if (o_report.valid === 1'b1) take(2, {o_report.hundreds, o_report.tens,
                o_report.ones, 3'h0, o_report.ok});
            if (o_selfcheck_done === 1'b1) take(3, {15'h0800, o_selfcheck_ok});
            if (o_refused === 1'b1) take(3, 16'h2000);
            if (o_hang_up === 1'b1) take(3, 16'h3000);
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic cmd(input cmd_e c);
        i_cmd_valid = 1'b1;
        i_cmd       = c;
        cyc(1);
        i_cmd_valid = 1'b0;
        i_cmd       = CMD_NONE;
    endtask

    task automatic wait_check();
        for (int n = 0; n < 200 && o_selfcheck_done !== 1'b1; n++) cyc(1);
        cyc(2);
    endtask

    // want bit 0: byte comes back to the terminal, bit 1: byte goes out on the line
    task automatic chars(input bit on_line, input int n, input logic [1:0] want);
        logic [7:0] d;
        repeat (n) begin
            d = 8'($random(seed));
            if (on_line) tb_line = '{valid: 1'b1, data: d};
            else i_term_rx = '{valid: 1'b1, data: d};
            if (want[0]) exp_q[0].push_back({8'h00, d});
            if (want[1]) exp_q[1].push_back({8'h00, d});
            cyc(1);
        end
        tb_line   = '0;
        i_term_rx = '0;
    endtask

    task automatic timed(input int d);
        i_test_duration_setting = 8'(d);
        cmd(CMD_LOCAL_ANALOG_ECHO);
        cyc(d * SEC - 2);
        `CHK(o_test_active, 1'b1)
        cyc(4);
        `CHK(o_test_active, 1'b0)
    endtask

    // ready drops before the stop so no echoed byte is still in flight
    task automatic pattern(input cmd_e c, input int n, input int ncor, input bit rnd,
                           input bit hang);
        int base;
        int e;
        base     = bad;
        lfsr     = LFSR_SEED;
        pat_mode = 1'b1;
        cmd(c);
        `CHK(o_analog_loop, c == CMD_LOCAL_PATTERN_TEST)
        `CHK(o_remote_loop_ask, c == CMD_REMOTE_PATTERN_TEST)
        for (int i = 0; i < n; i++) begin
            i_line_tx_ready = rnd ? 1'($random(seed)) : 1'b1;
            corrupt         = i < ncor;
            // terminal typing during a pattern test must never come back
            i_term_rx       = '{valid: 1'($random(seed)), data: 8'($random(seed))};
            cyc(1);
        end
        i_line_tx_ready = 1'b0;
        corrupt         = 1'b0;
        i_term_rx       = '0;
        cyc(4);
        e = bad - base;
        if (e > 999) e = 999;
        exp_q[2].push_back({4'(e / 100), 4'(e / 10 % 10), 4'(e % 10), 4'h1});
        if (hang) exp_q[3].push_back(16'h3000);
        cmd(hang ? CMD_HANG_UP : CMD_STOP_TEST);
        cyc(2);
        pat_mode = 1'b0;
        `CHK(o_test_active, 1'b0)
    endtask

    initial begin
        seed = 32'h54b6;
        i_rst = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd = CMD_NONE;
        i_test_duration_setting = 8'h00;
        i_link = '{1'b1, CONN_DIRECT, 15'd1200, 1'b0};
        i_rmt_loop_req = 1'b0;
        i_rmt_loop_end = 1'b0;
        i_term_rx = '0;
        tb_line = '0;
        i_line_tx_ready = 1'b0;
        echo_en = 1'b0;
        corrupt = 1'b0;
        pat_mode = 1'b0;
        fail_sel = 3'h0;
        exp_q[3].push_back(16'h1001);
        cyc(4);
        i_rst = 1'b0;
        wait_check();
        foreach (bad_l[i]) begin
            foreach (loops[j]) begin
                i_link = bad_l[i];
                exp_q[3].push_back(16'h2000);
                cmd(loops[j]);
                cyc(1);
                `CHK(o_test_active, 1'b0)
            end
        end
        i_link = '{1'b1, CONN_DIRECT, 15'd1200, 1'b0};
        cmd(CMD_LOCAL_ANALOG_ECHO);
        `CHK(o_analog_loop, 1'b1)
        chars(1'b0, 8, 2'b01);
        cyc(300);
        `CHK(o_test_active, 1'b1)
        cmd(CMD_STOP_TEST);
        cyc(1);
        `CHK(o_test_active, 1'b0)
        i_link = '{1'b1, CONN_NORMAL, 15'd2400, 1'b0};
        echo_en = 1'b1;
        cmd(CMD_REMOTE_DIGITAL_ECHO);
        `CHK(o_remote_loop_ask, 1'b1)
        chars(1'b0, 6, 2'b11);
        cyc(6);
        cmd(CMD_STOP_TEST);
        echo_en = 1'b0;
        cyc(1);
        cmd(CMD_LOCAL_DIGITAL_ECHO);
        chars(1'b1, 6, 2'b10);
        cyc(4);
        cmd(CMD_STOP_TEST);
        cyc(1);
        timed(1);
        timed(255);
        echo_en = 1'b1;
        pattern(CMD_LOCAL_PATTERN_TEST, 200, 40, 1'b1, 1'b0);
        pattern(CMD_LOCAL_PATTERN_TEST, 1100, 1100, 1'b0, 1'b0);
        pattern(CMD_REMOTE_PATTERN_TEST, 100, 0, 1'b1, 1'b1);
        echo_en = 1'b0;
        i_rmt_loop_req = 1'b1;
        cyc(1);
        i_rmt_loop_req = 1'b0;
        cyc(2);
        `CHK(o_test_active, 1'b0)
        cmd(CMD_ACCEPT_REMOTE_LOOP);
        cyc(1);
        i_rmt_loop_req = 1'b1;
        cyc(1);
        i_rmt_loop_req = 1'b0;
        cyc(1);
        `CHK(o_test_active, 1'b1)
        chars(1'b1, 4, 2'b10);
        cyc(3);
        i_rmt_loop_end = 1'b1;
        cyc(1);
        i_rmt_loop_end = 1'b0;
        cyc(2);
        `CHK(o_test_active, 1'b0)
        cmd(CMD_IGNORE_REMOTE_LOOP);
        i_rmt_loop_req = 1'b1;
        cyc(1);
        i_rmt_loop_req = 1'b0;
        cyc(2);
        `CHK(o_test_active, 1'b0)
        fail_sel = 3'b010;
        exp_q[3].push_back(16'h1000);
        cmd(CMD_POWER_UP_TEST);
        wait_check();
        exp_q[3].push_back(16'h3000);
        cmd(CMD_HANG_UP);
        cyc(1);
        cmd(CMD_STOP_TEST);
        cyc(4);
        foreach (exp_q[k]) `CHK(exp_q[k].size(), 0)
        finish_test();
    end
endmodule // loopdiag_ctrl_test
`default_nettype wire

// ===== loopdiag_far_end.sv
// far-end model: self-check engine and remote modem line
`timescale 1ns/1ps
`default_nettype none
module loopdiag_far_end (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // self-check engine
    input  wire logic [2:0]          i_check_sel,
    input  wire logic [2:0]          i_fail_sel,
    output logic                     o_check_done,
    output logic                     o_check_pass,
    // line side
    input  wire loopdiag_pkg::char_s i_line_tx,
    input  wire loopdiag_pkg::char_s i_tb_line,
    input  wire logic                i_echo_en,
    input  wire logic                i_corrupt,
    output loopdiag_pkg::char_s      o_line_rx,
    output int                       o_bad_cnt
);
    import loopdiag_pkg::*;
    logic [2:0] sel_q;
    logic [2:0] cnt_q;
    // a new item under check restarts the answer delay
    always_ff @(posedge i_clk) begin
        sel_q        <= i_check_sel;
        o_check_done <= 1'b0;
        if (i_rst || i_check_sel != sel_q) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1;
        end
        if (i_rst) begin
            o_check_pass <= 1'b0;
        end else if (i_check_sel != 3'h0 && cnt_q == 3'h3) begin
            o_check_done <= 1'b1;
            o_check_pass <= (i_check_sel & i_fail_sel) == 3'h0;
        end
    end
    // an idle line inverts its data each cycle, never holding a stale copy two cycles running
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_line_rx <= '0;
            o_bad_cnt <= 0;
        end else if (i_echo_en) begin
            o_line_rx.valid <= i_line_tx.valid;
            o_line_rx.data  <= i_line_tx.valid ? i_line_tx.data ^ (i_corrupt ? 8'h5a : 8'h00)
                                               : ~o_line_rx.data;
            if (i_line_tx.valid && i_corrupt) o_bad_cnt <= o_bad_cnt + 1;
        end else begin
            o_line_rx <= i_tb_line.valid ? i_tb_line : '{valid: 1'b0, data: ~o_line_rx.data};
        end
    end
endmodule // loopdiag_far_end
`default_nettype wire

// ===== loopdiag_pkg.sv
// shared types and constants for the loopback diagnostics controller
package loopdiag_pkg;

    // terminal commands after parsing
    typedef enum logic [3:0] {
        CMD_NONE                    = 4'h0,
        CMD_STOP_TEST               = 4'h1,
        CMD_LOCAL_ANALOG_ECHO       = 4'h2,
        CMD_LOCAL_DIGITAL_ECHO      = 4'h3,
        CMD_REMOTE_DIGITAL_ECHO     = 4'h4,
        CMD_REMOTE_PATTERN_TEST     = 4'h5,
        CMD_LOCAL_PATTERN_TEST      = 4'h6,
        CMD_ACCEPT_REMOTE_LOOP      = 4'h7,
        CMD_IGNORE_REMOTE_LOOP      = 4'h8,
        CMD_HANG_UP                 = 4'h9,
        CMD_POWER_UP_TEST           = 4'ha
    } cmd_e;

    typedef enum logic [1:0] {
        CONN_NORMAL   = 2'h0,
        CONN_DIRECT   = 2'h1,
        CONN_RELIABLE = 2'h2,
        CONN_AUTO     = 2'h3
    } conn_mode_e;

    // which loopback is running
    typedef enum logic [2:0] {
        TK_LOCAL_ANALOG_ECHO   = 3'h0,
        TK_LOCAL_PATTERN       = 3'h1,
        TK_REMOTE_DIGITAL_ECHO = 3'h2,
        TK_REMOTE_PATTERN      = 3'h3,
        TK_LOCAL_DIGITAL_ECHO  = 3'h4,
        TK_SERVE_REMOTE        = 3'h5
    } test_kind_e;

    typedef struct packed {
        logic       connected;
        conn_mode_e mode;
        logic [14:0] bps;
        logic       fsk_hdx;
    } link_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } char_s;

    typedef struct packed {
        logic       valid;
        logic [3:0] hundreds;
        logic [3:0] tens;
        logic [3:0] ones;
        logic       ok;
    } report_s;

    localparam logic [14:0] MIN_LOOP_BPS  = 15'd1200;
    localparam logic [3:0]  BCD_TOP_DIGIT = 4'h9;
    localparam logic [7:0]  LFSR_SEED     = 8'h01;
    localparam logic [7:0]  LFSR_TAPS     = 8'hb8;
    localparam logic [2:0]  CHECK_FIRST   = 3'b001;
    localparam int          CHECK_PROGRAM = 0;
    localparam int          CHECK_RAM     = 1;
    localparam int          CHECK_PARTS   = 2;
    localparam longint      SECOND_NS     = 64'd1000000000;
    localparam longint      CLK_PERIOD_NS = 64'd10;
    localparam int          SEC_CYCLES    = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage
